// ### eba_pkg.sv
// Package for the external bus wait-state and arbitration control pair.
// Assumes one 25 MHz clock shared by both ends and an active-low async reset.
package eba_pkg;
    localparam int          CLOCK_MHZ         = 25;
    localparam int          WAIT_WIDTH        = 4;
    localparam int          SYNC_STAGES       = 3;
    localparam logic [3:0]  WAIT_RESET        = 4'h1;
    localparam logic        ACK_SYNC_RESET    = 1'b1;
    localparam logic        ARB_SYNC_RESET    = 1'b1;
    localparam logic        HOLD_RESET        = 1'b0;
    // Arbiter spacing between grant removal and next grant, in ns
    localparam int          REGRANT_GAP_NS    = 200;
    localparam int          REGRANT_GAP_CYC   = (REGRANT_GAP_NS * CLOCK_MHZ + 999) / 1000;
    localparam logic [3:0]  REGRANT_GAP_COUNT = 4'(REGRANT_GAP_CYC);
    // Responder acknowledge delay after a cycle starts
    localparam logic [3:0]  ACK_DELAY_RESET   = 4'h2;
    // Control register offsets and field positions
    localparam logic [7:0]  OFS_CONFIG        = 8'h00;
    localparam logic [7:0]  OFS_CMD           = 8'h04;
    localparam logic [7:0]  OFS_STATUS        = 8'h08;
    localparam int          CFG_ACK_SYNC      = 4;
    localparam int          CFG_HOLD          = 5;
    localparam int          CFG_PARK          = 6;
    localparam int          CFG_ARB_SYNC      = 13;
    localparam int          CMD_START         = 0;

    typedef enum logic [1:0] {
        EBA_SLAVE,
        EBA_PENDING,
        EBA_MASTER,
        EBA_RELEASE
    } eba_arb_state_type;

    typedef enum logic [1:0] {
        EBA_IDLE,
        EBA_WAIT,
        EBA_ACKED,
        EBA_DONE
    } eba_cyc_state_type;
endpackage

// ### eba_link_if.sv
// Interface joining the device port and the external responder/arbiter.
// Resolves the open-drain busy line and its pull-up here from the enables.
`timescale 1ns/100ps
`default_nettype none
interface eba_link_if;
    logic store_strobe_n_o;
    logic store_strobe_n_oe;
    logic transfer_ack_n;
    logic bus_request_n;
    logic bus_grant_n;
    logic bus_busy_n_o;
    logic bus_busy_n_oe;
    logic bus_busy_n_far_o;
    logic bus_busy_n_far_oe;
    logic bus_busy_n;
    logic clock_output;

    assign bus_busy_n = (bus_busy_n_oe & ~bus_busy_n_o) | (bus_busy_n_far_oe & ~bus_busy_n_far_o) ? 1'b0 : 1'b1;

    modport device (
        output store_strobe_n_o, store_strobe_n_oe, bus_request_n, bus_busy_n_o, bus_busy_n_oe, clock_output,
        input  transfer_ack_n, bus_grant_n, bus_busy_n
    );
    modport partner (
        input  store_strobe_n_o, store_strobe_n_oe, bus_request_n, clock_output, bus_busy_n,
        output transfer_ack_n, bus_grant_n, bus_busy_n_far_o, bus_busy_n_far_oe
    );
endinterface
`default_nettype wire

// ### eba_partner.sv
// Far end: external responder driving acknowledge plus a single-device arbiter.
// Assumes the device end on the same clock; the bus busy pull-up is in the interface.
`timescale 1ns/100ps
`default_nettype none
module eba_partner (
    // Clock and reset
    input  wire logic        I_CLOCK,
    input  wire logic        I_RESET_N,
    // User side
    input  wire logic [3:0]  I_ACK_DELAY,
    input  wire logic        I_GRANT_ENABLE,
    output logic             O_GRANTED,
    // Link
    eba_link_if.partner      link
);
    import eba_pkg::*;

    typedef struct packed {
        logic [3:0] ack_cnt;
        logic       ack_n;
        logic       grant_n;
        logic [3:0] gap_cnt;
        logic       strobe_d;
    } eba_far_type;

    eba_far_type s_reg;
    eba_far_type s_next;

    always_comb begin
        logic active;
        active = 1'b0;
        s_next = s_reg;
        // Static responder only; never a DRAM-type access to stretch
        active = link.store_strobe_n_oe & ~link.store_strobe_n_o;
        s_next.strobe_d = active;
        if (active) begin
            if (s_reg.ack_cnt < I_ACK_DELAY) begin
                s_next.ack_cnt = s_reg.ack_cnt + 4'h1;
            end else begin
                s_next.ack_n = 1'b0;
            end
        end else begin
            s_next.ack_cnt = 4'h0;
            s_next.ack_n   = 1'b1;
        end
        if (s_reg.gap_cnt != 4'h0) begin
            s_next.gap_cnt = s_reg.gap_cnt - 4'h1;
        end
        // Arbiter parks the grant until I_GRANT_ENABLE is dropped
        if (!s_reg.grant_n && !I_GRANT_ENABLE) begin
            s_next.grant_n = 1'b1;
            s_next.gap_cnt = REGRANT_GAP_COUNT;
        end else if (s_reg.grant_n && I_GRANT_ENABLE && !link.bus_request_n && s_reg.gap_cnt == 4'h0) begin
            s_next.grant_n = 1'b0;
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            s_reg <= '{ack_cnt: 4'h0, ack_n: 1'b1, grant_n: 1'b1, gap_cnt: 4'h0, strobe_d: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign link.transfer_ack_n    = s_reg.ack_n;
    assign link.bus_grant_n       = s_reg.grant_n;
    assign link.bus_busy_n_far_o  = 1'b1;
    assign link.bus_busy_n_far_oe = 1'b0;
    assign O_GRANTED              = ~s_reg.grant_n;
endmodule
`default_nettype wire

// ### eba_device.sv
// Device end: store strobe, acknowledge-extended wait states, bus arbitration.
// Assumes software registers on APB; link inputs are asynchronous pins.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Master drives store strobe, else tri-stated
// - Ignore acknowledge unless master and cycling
// - Withheld acknowledge stretches cycle beyond programmed
// - Cycle ends one clock after acknowledge
// - Waits are max of programmed, acknowledge
// - Responder acknowledges late, releases before next
// - Program at least one wait first
// - Mode bit selects synchronous or synchronised acknowledge
// - No acknowledge extension on DRAM accesses
// - Request bus when needed, drop afterwards
// - Request independent of role; parking allowed
// - Hold bit keeps request, also in standby
// - Request only for external accesses
// - Reset drops request, arbitration to slave
// - After grant, wait for busy released
// - Grant removed: leave after current cycle
// - Enable bit synchronises grant and busy
// - Arbiter leaves gap between grants
// - Take bus after busy free, assert busy
// - Master may park, keeping busy asserted
// - Release busy: drive high, then float
// - Ignore grant and busy in reset, standby
module eba_device (
    // Clock and reset
    input  wire logic        I_CLOCK,
    input  wire logic        I_RESET_N,
    // APB slave
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [7:0]  I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic [31:0]      O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    // Core side
    input  wire logic        I_STANDBY,
    // Link
    eba_link_if.device       link
);
    import eba_pkg::*;

    typedef struct packed {
        logic [3:0]        wait_min;
        logic              ack_sync_select;
        logic              request_hold;
        logic              park;
        logic              arb_sync_enable;
        logic              pending;
        logic [15:0]       done_count;
        logic [2:0]        ack_sy;
        logic [2:0]        grant_sy;
        logic [2:0]        busy_sy;
        logic              ack_f;
        logic              grant_f;
        logic              busy_f;
        eba_arb_state_type arb;
        eba_cyc_state_type cyc;
        logic [3:0]        wait_cnt;
        logic              req_n;
        logic              strobe_n;
        logic              bb_o;
        logic              bb_oe;
        logic [31:0]       rdata;
    } eba_dev_type;

    eba_dev_type s_reg;
    eba_dev_type s_next;

    function automatic logic agree(input logic [2:0] sy, input logic prev);
        return (sy[1] == sy[2]) ? sy[2] : prev;
    endfunction

    always_comb begin
        logic ack_lvl;
        logic grant_lvl;
        logic busy_lvl;
        logic need;
        logic wr;
        logic rd;
        ack_lvl   = 1'b0;
        grant_lvl = 1'b0;
        busy_lvl  = 1'b0;
        need      = 1'b0;
        wr        = 1'b0;
        rd        = 1'b0;
        s_next    = s_reg;
        s_next.ack_sy   = {s_reg.ack_sy[1:0], ~link.transfer_ack_n};
        s_next.grant_sy = {s_reg.grant_sy[1:0], ~link.bus_grant_n};
        s_next.busy_sy  = {s_reg.busy_sy[1:0], ~link.bus_busy_n};
        s_next.ack_f    = agree(s_reg.ack_sy, s_reg.ack_f);
        s_next.grant_f  = agree(s_reg.grant_sy, s_reg.grant_f);
        s_next.busy_f   = agree(s_reg.busy_sy, s_reg.busy_f);
        // Synchronous mode saves latency but needs setup-clean acknowledge
        ack_lvl   = s_reg.ack_sync_select ? ~link.transfer_ack_n : s_reg.ack_f;
        grant_lvl = s_reg.arb_sync_enable ? s_reg.grant_f : ~link.bus_grant_n;
        busy_lvl  = s_reg.arb_sync_enable ? s_reg.busy_f : ~link.bus_busy_n;
        if (I_STANDBY) begin
            grant_lvl = 1'b0;
            busy_lvl  = 1'b1;
        end
        // APB access, zero wait states
        wr = I_PSEL & I_PENABLE & I_PWRITE;
        rd = I_PSEL & ~I_PENABLE & ~I_PWRITE;
        if (wr && I_PADDR == OFS_CONFIG) begin
            s_next.wait_min        = I_PWDATA[3:0];
            s_next.ack_sync_select = I_PWDATA[CFG_ACK_SYNC];
            s_next.request_hold    = I_PWDATA[CFG_HOLD];
            s_next.park            = I_PWDATA[CFG_PARK];
            s_next.arb_sync_enable = I_PWDATA[CFG_ARB_SYNC];
        end
        if (wr && I_PADDR == OFS_CMD && I_PWDATA[CMD_START]) begin
            s_next.pending = 1'b1;
        end
        if (rd) begin
            case (I_PADDR)
                OFS_CONFIG: s_next.rdata = {18'h0, s_reg.arb_sync_enable, 6'h0, s_reg.park,
                                            s_reg.request_hold, s_reg.ack_sync_select, s_reg.wait_min};
                OFS_STATUS: s_next.rdata = {s_reg.done_count, 12'h0, s_reg.cyc == EBA_IDLE ? 1'b0 : 1'b1,
                                            s_reg.pending, s_reg.arb == EBA_MASTER ? 1'b1 : 1'b0, ~s_reg.req_n};
                default:    s_next.rdata = 32'h0;
            endcase
        end
        // Only queued or running external accesses count as need
        need = s_reg.pending | (s_reg.cyc != EBA_IDLE);
        if (I_STANDBY) begin
            s_next.req_n = s_reg.request_hold ? s_reg.req_n : 1'b1;
        end else begin
            s_next.req_n = ~(need | s_reg.request_hold);
        end
        // Cycle engine
        case (s_reg.cyc)
            EBA_IDLE: begin
                s_next.strobe_n = 1'b1;
                if (s_reg.pending && s_reg.arb == EBA_MASTER && grant_lvl) begin
                    s_next.pending  = 1'b0;
                    s_next.cyc      = EBA_WAIT;
                    s_next.strobe_n = 1'b0;
                    s_next.wait_cnt = s_reg.wait_min;
                end
            end
            EBA_WAIT: begin
                if (s_reg.wait_cnt != 4'h0) begin
                    s_next.wait_cnt = s_reg.wait_cnt - 4'h1;
                end
                // Zero programmed waits are stretched by acknowledge like one wait
                if (s_reg.wait_cnt <= 4'h1 && ack_lvl) begin
                    s_next.cyc = EBA_ACKED;
                end
            end
            EBA_ACKED: begin
                s_next.cyc      = EBA_DONE;
                s_next.strobe_n = 1'b1;
                s_next.done_count = s_reg.done_count + 16'h1;
            end
            EBA_DONE: begin
                s_next.cyc = EBA_IDLE;
            end
            default: s_next.cyc = EBA_IDLE;
        endcase
        // Arbitration
        case (s_reg.arb)
            EBA_SLAVE: begin
                s_next.bb_oe = 1'b0;
                if (grant_lvl && !s_reg.req_n) begin
                    s_next.arb = EBA_PENDING;
                end
            end
            EBA_PENDING: begin
                if (!grant_lvl) begin
                    s_next.arb = EBA_SLAVE;
                end else if (!busy_lvl) begin
                    s_next.arb   = EBA_MASTER;
                    s_next.bb_o  = 1'b0;
                    s_next.bb_oe = 1'b1;
                end
            end
            EBA_MASTER: begin
                // Parking keeps busy asserted to reuse the bus
                if ((!grant_lvl || (!s_reg.park && !need)) && s_reg.cyc == EBA_IDLE
                    && s_next.cyc == EBA_IDLE) begin
                    s_next.arb  = EBA_RELEASE;
                    s_next.bb_o = 1'b1;
                end
            end
            EBA_RELEASE: begin
                s_next.arb       = EBA_SLAVE;
                s_next.bb_oe     = 1'b0;
            end
            default: s_next.arb = EBA_SLAVE;
        endcase
    end

    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            s_reg <= '{wait_min: WAIT_RESET, ack_sync_select: ACK_SYNC_RESET, request_hold: HOLD_RESET,
                       park: 1'b0, arb_sync_enable: ARB_SYNC_RESET, pending: 1'b0,
                       done_count: 16'h0, ack_sy: 3'h0, grant_sy: 3'h0, busy_sy: 3'h0,
                       ack_f: 1'b0, grant_f: 1'b0, busy_f: 1'b0, arb: EBA_SLAVE, cyc: EBA_IDLE,
                       wait_cnt: 4'h0, req_n: 1'b1, strobe_n: 1'b1, bb_o: 1'b1, bb_oe: 1'b0,
                       rdata: 32'h0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign O_PRDATA          = s_reg.rdata;
    assign O_PREADY          = 1'b1;
    assign O_PSLVERR         = 1'b0;
    assign link.bus_request_n     = s_reg.req_n;
    assign link.store_strobe_n_o  = s_reg.strobe_n;
    assign link.store_strobe_n_oe = (s_reg.arb == EBA_MASTER) ? 1'b1 : 1'b0;
    assign link.bus_busy_n_o      = s_reg.bb_o;
    assign link.bus_busy_n_oe     = s_reg.bb_oe;
    assign link.clock_output      = I_CLOCK;
endmodule
`default_nettype wire

// ### eba_asserts.sv
// Checker for the device side of the external bus link.
// Assumes the bench wires in the link signals beside the interface.
`timescale 1ns/100ps
`default_nettype none
module eba_asserts (
    // Clock and reset
    input  wire logic I_CLOCK,
    input  wire logic I_RESET_N,
    // Link
    input  wire logic store_strobe_n_o,
    input  wire logic store_strobe_n_oe,
    input  wire logic transfer_ack_n,
    input  wire logic bus_request_n,
    input  wire logic bus_grant_n,
    input  wire logic bus_busy_n_o,
    input  wire logic bus_busy_n_oe,
    input  wire logic bus_busy_n
);
    logic ack_seen_reg;
    logic ack_seen_next;
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (!I_RESET_N);
    // Cleared between strobes, so a stray ack cannot count
    always_comb begin
        ack_seen_next = ack_seen_reg;
        if (store_strobe_n_o)
            ack_seen_next = 1'b0;
        else if (!transfer_ack_n)
            ack_seen_next = 1'b1;
    end
    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N)
            ack_seen_reg <= 1'b0;
        else
            ack_seen_reg <= ack_seen_next;
    end
    strobe_drive_a: assert property (!store_strobe_n_o |-> store_strobe_n_oe)
        else $error("strobe low while not driven");
    strobe_master_a: assert property (store_strobe_n_oe |-> bus_busy_n_oe && !bus_busy_n_o)
        else $error("strobe driven without holding busy");
    ack_needed_a: assert property ($rose(store_strobe_n_o) |-> ack_seen_reg)
        else $error("cycle ended without acknowledge");
    ack_finish_a: assert property (!store_strobe_n_o && !transfer_ack_n |-> ##[1:22] store_strobe_n_o)
        else $error("cycle not ended after acknowledge");
    reset_quiet_a: assert property (disable iff (1'b0)
        !I_RESET_N |-> bus_request_n && !store_strobe_n_oe && !bus_busy_n_oe)
        else $error("outputs active during reset");
    busy_float_a: assert property (bus_busy_n_oe && bus_busy_n_o |=> !bus_busy_n_oe)
        else $error("busy driven high longer than one cycle");
    active_pullup_a: assert property ($fell(bus_busy_n_oe) |-> $past(bus_busy_n_o))
        else $error("busy released while driven low");
    busy_take_a: assert property ($rose(bus_busy_n_oe) |-> !bus_busy_n_o && $past(bus_busy_n))
        else $error("bus taken while busy");
    grant_drop_a: assert property ($rose(bus_grant_n) |-> ##[1:40] !bus_busy_n_oe)
        else $error("bus kept after grant removed");
endmodule
`default_nettype wire

// ### tb_top.sv
// Bench joining the device end to the responder and arbiter end.
// Assumes one shared clock; the busy pull-up is resolved in the interface.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import eba_pkg::*;
    logic        clock = 1'b0;
    logic        reset_n = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        granted;
    logic        standby = 1'b0;
    logic [3:0]  ack_delay = 4'h2;
    logic        grant_en = 1'b1;
    logic [31:0] rd;
    int          miscompares = 0;
    int          total_checks = 0;
    always #20 clock = ~clock;
    eba_link_if u_eba_link_if ();
    wire logic stb_n = u_eba_link_if.store_strobe_n_o;
    wire logic stb_oe = u_eba_link_if.store_strobe_n_oe;
    wire logic req_n = u_eba_link_if.bus_request_n;
    wire logic busy_oe = u_eba_link_if.bus_busy_n_oe;
    eba_device u_eba_device (.I_CLOCK(clock), .I_RESET_N(reset_n), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .I_STANDBY(standby), .link(u_eba_link_if));
    eba_partner u_eba_partner (.I_CLOCK(clock), .I_RESET_N(reset_n), .I_ACK_DELAY(ack_delay),
        .I_GRANT_ENABLE(grant_en), .O_GRANTED(granted), .link(u_eba_link_if));
    eba_asserts u_eba_asserts (.I_CLOCK(clock), .I_RESET_N(reset_n), .store_strobe_n_o(stb_n),
        .store_strobe_n_oe(stb_oe), .transfer_ack_n(u_eba_link_if.transfer_ack_n), .bus_request_n(req_n),
        .bus_grant_n(u_eba_link_if.bus_grant_n), .bus_busy_n_o(u_eba_link_if.bus_busy_n_o),
        .bus_busy_n_oe(busy_oe), .bus_busy_n(u_eba_link_if.bus_busy_n));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        if (miscompares == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic timed_out();
        miscompares++;
        $display("unexpected at %0t: wait limit reached", $time);
        report_and_stop();
    endtask
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        int k;
        k = 0;
        @(posedge clock);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= addr;
        pwdata <= data;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            k++;
            if (k > 20)
                timed_out();
        end while (pready !== 1'b1);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // 0 strobe, 1 busy enable, 2 request
    task automatic wait_for(input int s, input logic lvl, output int cnt);
        cnt = 0;
        #1;
        while ((s == 0 ? stb_n : s == 1 ? busy_oe : req_n) !== lvl) begin
            @(posedge clock);
            #1;
            cnt++;
            if (cnt > 80)
                timed_out();
        end
    endtask
    task automatic t_reset();
        apb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h0000_2011);
        apb(1'b0, 8'h08, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 8'h1C, 32'h0);
        check(rd, 32'h0);
        check(pslverr, 1'b0);
        check({req_n, stb_oe, busy_oe}, 3'b100);
    endtask
    // Strobe low length: the later of programmed waits and acknowledge plus one clock
    task automatic t_cycle(input logic [31:0] cfg, input logic [3:0] dly, input int exp_len);
        int w;
        int len;
        apb(1'b1, 8'h00, cfg);
        ack_delay <= dly;
        apb(1'b1, 8'h04, 32'h1);
        wait_for(0, 1'b0, w);
        wait_for(0, 1'b1, len);
        check(32'(len), 32'(exp_len));
        wait_for(1, 1'b0, w);
        apb(1'b0, 8'h08, 32'h0);
        check(rd[3:0], 4'h0);
    endtask
    task automatic t_hold();
        int w;
        apb(1'b1, 8'h00, 32'h0000_2031);
        wait_for(2, 1'b0, w);
        @(posedge clock);
        standby <= 1'b1;
        repeat (8) @(posedge clock);
        check(req_n, 1'b0);
        apb(1'b1, 8'h00, 32'h0000_2011);
        wait_for(2, 1'b1, w);
        @(posedge clock);
        standby <= 1'b0;
        wait_for(1, 1'b0, w);
    endtask
    task automatic t_park();
        int w;
        apb(1'b1, 8'h00, 32'h0000_2051);
        apb(1'b1, 8'h04, 32'h1);
        wait_for(0, 1'b0, w);
        wait_for(2, 1'b1, w);
        repeat (10) @(posedge clock);
        check({req_n, busy_oe}, 2'b11);
        grant_en <= 1'b0;
        wait_for(1, 1'b0, w);
        apb(1'b1, 8'h04, 32'h1);
        repeat (20) @(posedge clock);
        check({req_n, stb_oe, granted}, 3'b000);
        grant_en <= 1'b1;
        wait_for(0, 1'b0, w);
        wait_for(0, 1'b1, w);
    endtask
    initial begin
        reset_n <= 1'b0;
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        t_reset();
        t_cycle(32'h0000_2011, 4'h4, 7);
        t_cycle(32'h0000_2016, 4'h1, 7);
        t_cycle(32'h0000_2003, 4'h3, 10);
        apb(1'b0, 8'h08, 32'h0);
        check(rd[31:16], 16'h0003);
        t_hold();
        t_park();
        report_and_stop();
    end
endmodule
`default_nettype wire
